// [hdl/usfd_map.svh]
// register offsets, field positions, reset values and timing counts
`ifndef USFD_MAP_SVH
`define USFD_MAP_SVH
`define USFD_ADDR_W 8
`define USFD_OFF_RX_DATA 8'h00
`define USFD_OFF_TXDATA 8'h04
`define USFD_OFF_STATUS 8'h08
`define USFD_OFF_CTRL_SECOND 8'h0C
`define USFD_OFF_BAUD 8'h10
`define USFD_OFF_INTSTAT 8'h14
`define USFD_OFF_INTMASK 8'h18
// control_reg_second bit positions
`define USFD_CB_DETECT_EN 0
`define USFD_CB_RXEN 1
`define USFD_CB_TXEN 2
`define USFD_CB_ODME 3
`define USFD_CB_TXDIR 4
// status bit positions
`define USFD_ST_RXC 0
`define USFD_ST_RXS 1
`define USFD_ST_TXBUSY 2
`define USFD_ST_ARMED 3
// interrupt status bit positions
`define USFD_IRQ_RXC 0
`define USFD_IRQ_RXS 1
`define USFD_IRQ_TXDONE 2
`define USFD_IRQ_FERR 3
// reset values
`define USFD_CTRL_SECOND_RST 5'h00
`define USFD_BAUD_RST 16'h0036
`define USFD_MASK_RST 4'h0
// oversampling: last sample index of a bit and the mid-bit sample of the start bit
`define USFD_OVS_LAST 4'hF
`define USFD_OVS_MID 4'h7
`define USFD_FRAME_BITS 4'hA
`endif

// [hdl/usfd_pkg.sv]
// types shared by the serial receiver start-of-frame block
package usfd_pkg;
    typedef enum logic [1:0] {
        USFD_RX_IDLE = 2'b00,
        USFD_RX_START = 2'b01,
        USFD_RX_DATA = 2'b10,
        USFD_RX_STOP = 2'b11
    } usfd_rx_state_t;

    typedef struct packed {
        logic [7:0] addr;
        logic [31:0] wdata;
        logic wr;
        logic rd;
    } usfd_bus_req_t;

    typedef struct packed {
        logic txd_dir_out;
        logic open_drain;
        logic tx_en;
        logic rx_en;
        logic sfd_en;
    } usfd_ctrl_t;

    typedef struct packed {
        usfd_rx_state_t rx_state;
        logic [3:0] rx_ticks;
        logic [2:0] rx_bitn;
        logic [7:0] rx_shift;
        logic [7:0] rx_data;
        logic rx_complete_flag;
        logic rx_start_flag;
        logic sfd_armed;
        logic rx_prev;
        usfd_ctrl_t ctrl;
        logic [15:0] baud;
        logic [3:0] int_stat;
        logic [3:0] int_mask;
        logic [31:0] rdata;
        logic tx_busy;
        logic [3:0] tx_ticks;
        logic [3:0] tx_bitn;
        logic [9:0] tx_shift;
        logic tx_bit;
    } usfd_state_t;
endpackage

// [hdl/usfd_sync.sv]
// three-stage pin synchroniser with agreement filter on the last two stages
`timescale 1ns/1ps
module usfd_sync (
    input wire logic mclk,
    input wire logic reset,
    input wire logic pin_in,
    output logic level
);
    logic s1_reg;
    logic s2_reg;
    logic s3_reg;

    // idle serial line is high, so every stage resets to one
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            s1_reg <= 1'b1;
            s2_reg <= 1'b1;
            s3_reg <= 1'b1;
            level <= 1'b1;
        end else begin
            s1_reg <= pin_in;
            s2_reg <= s1_reg;
            s3_reg <= s2_reg;
            // a change counts only once two later stages agree
            if (s2_reg == s3_reg) begin
                level <= s3_reg;
            end
        end
    end
endmodule // usfd_sync

// [hdl/usfd_baud.sv]
// oversampling tick generator, one pulse every divisor+1 clocks
`timescale 1ns/1ps
module usfd_baud #(
    parameter int W = 16
) (
    input wire logic mclk,
    input wire logic reset,
    input wire logic [W-1:0] divisor,
    output logic tick
);
    logic [W-1:0] cnt_reg;

    // restart on reaching the divisor; divisor 0 ticks every clock
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            cnt_reg <= '0;
            tick <= 1'b0;
        end else if (cnt_reg >= divisor) begin
            cnt_reg <= '0;
            tick <= 1'b1;
        end else begin
            cnt_reg <= cnt_reg + W'(1);
            tick <= 1'b0;
        end
    end
endmodule // usfd_baud

// [hdl/usfd_top.sv]
// serial transceiver with start-of-frame detector and open-drain txd pin
// What this block does
// - with txd set as output the pin is driven high even in open-drain
// - in active mode the detector can arm while rx complete flag is 0
// - reading rx data mid-frame clears complete flag and, in active mode with detect enable 1, arms the detector
// - an armed detector takes the next falling edge as start bit
// - a detected start restarts reception, corrupting the current frame
// - in active mode rx start flag always reads 0, no interrupt
// - writing detect enable 0 turns detection off
// - re-enabling detection mid-frame corrupts data; remote must be quiet
//
// Design decisions made here: the strobed register port and the register offsets.
`timescale 1ns/1ps
`include "usfd_map.svh"
module usfd_top (
    input wire logic mclk,
    input wire logic reset,
    input wire usfd_pkg::usfd_bus_req_t bus,
    output logic [31:0] rdata,
    input wire logic standby,
    input wire logic rxd_in,
    output logic txd_o,
    output logic txd_oe_n,
    output logic irq
);
    import usfd_pkg::*;

    usfd_state_t st_reg;
    usfd_state_t st_next;
    logic rxd;
    logic tick;
    logic fall;

    // address match used by every register access
    function automatic logic hit(input logic [7:0] a, input logic [7:0] off);
        hit = (a == off);
    endfunction

    usfd_sync u_sync (
        .mclk(mclk),
        .reset(reset),
        .pin_in(rxd_in),
        .level(rxd)
    );

    usfd_baud #(.W(16)) u_baud (
        .mclk(mclk),
        .reset(reset),
        .divisor(st_reg.baud),
        .tick(tick)
    );

    assign fall = st_reg.rx_prev & ~rxd;
    assign rdata = st_reg.rdata;
    assign irq = |(st_reg.int_stat & st_reg.int_mask);

    // txd drive: direction-out drives both levels regardless of open-drain
    always_comb begin
        if (st_reg.ctrl.txd_dir_out) begin
            txd_o = st_reg.tx_bit;
            txd_oe_n = 1'b0;
        end else if (st_reg.ctrl.open_drain && st_reg.ctrl.tx_en) begin
            txd_o = 1'b0;
            txd_oe_n = st_reg.tx_bit;
        end else begin
            txd_o = 1'b1;
            txd_oe_n = 1'b1;
        end
    end

    // whole next state: bus, receiver, detector, transmitter, interrupts
    always_comb begin
        logic rd_rx;
        logic rx_busy;
        logic [3:0] ev;
        logic sfd_wr;
        logic [4:0] cb;
        rd_rx = bus.rd && hit(bus.addr, `USFD_OFF_RX_DATA);
        rx_busy = (st_reg.rx_state != USFD_RX_IDLE);
        ev = 4'h0;
        cb = bus.wdata[4:0];
        sfd_wr = bus.wr && hit(bus.addr, `USFD_OFF_CTRL_SECOND);
        st_next = st_reg;
        st_next.rx_prev = rxd;

        // register writes
        if (bus.wr) begin
            if (sfd_wr) begin
                st_next.ctrl = usfd_ctrl_t'(cb);
            end
            if (hit(bus.addr, `USFD_OFF_BAUD)) begin
                st_next.baud = bus.wdata[15:0];
            end
            if (hit(bus.addr, `USFD_OFF_INTMASK)) begin
                st_next.int_mask = bus.wdata[3:0];
            end
            if (hit(bus.addr, `USFD_OFF_TXDATA) && !st_reg.tx_busy
                    && st_reg.ctrl.tx_en) begin
                // stop bit, data lsb first, start bit
                st_next.tx_shift = {1'b1, bus.wdata[7:0], 1'b0};
                st_next.tx_busy = 1'b1;
                st_next.tx_ticks = 4'h0;
                st_next.tx_bitn = 4'h0;
            end
        end

        // a read of rx data hands the byte over and drops the complete flag
        if (rd_rx) begin
            st_next.rx_complete_flag = 1'b0;
            // the flaw: clearing mid-frame in active mode with detection enabled arms the detector
            if (rx_busy && st_reg.ctrl.sfd_en && !standby) begin
                st_next.sfd_armed = 1'b1;
            end
        end
        // enabling detection while a frame is arriving arms it as well
        if (sfd_wr && cb[`USFD_CB_DETECT_EN] && !st_reg.ctrl.sfd_en
                && rx_busy) begin
            st_next.sfd_armed = 1'b1;
        end
        if (sfd_wr && !cb[`USFD_CB_DETECT_EN]) begin
            st_next.sfd_armed = 1'b0;
        end

        // receiver, 16 samples per bit
        case (st_reg.rx_state)
            USFD_RX_IDLE: begin
                if (fall && st_reg.ctrl.rx_en) begin
                    st_next.rx_state = USFD_RX_START;
                    st_next.rx_ticks = 4'h0;
                    // genuine detection only counts in standby
                    if (standby && st_reg.ctrl.sfd_en) begin
                        ev[`USFD_IRQ_RXS] = 1'b1;
                    end
                end
            end
            USFD_RX_START: begin
                if (tick) begin
                    st_next.rx_ticks = 4'(st_reg.rx_ticks + 4'h1);
                    if (st_reg.rx_ticks == `USFD_OVS_MID) begin
                        st_next.rx_ticks = 4'h0;
                        st_next.rx_bitn = 3'h0;
                        // a high mid-bit was a glitch, not a start
                        st_next.rx_state = rxd ? USFD_RX_IDLE : USFD_RX_DATA;
                    end
                end
            end
            USFD_RX_DATA: begin
                if (tick) begin
                    st_next.rx_ticks = 4'(st_reg.rx_ticks + 4'h1);
                    if (st_reg.rx_ticks == `USFD_OVS_LAST) begin
                        st_next.rx_shift = {rxd, st_reg.rx_shift[7:1]};
                        st_next.rx_bitn = 3'(st_reg.rx_bitn + 3'h1);
                        if (st_reg.rx_bitn == 3'h7) begin
                            st_next.rx_state = USFD_RX_STOP;
                        end
                    end
                end
            end
            USFD_RX_STOP: begin
                if (tick) begin
                    st_next.rx_ticks = 4'(st_reg.rx_ticks + 4'h1);
                    if (st_reg.rx_ticks == `USFD_OVS_LAST) begin
                        st_next.rx_state = USFD_RX_IDLE;
                        if (rxd) begin
                            st_next.rx_data = st_reg.rx_shift;
                            ev[`USFD_IRQ_RXC] = 1'b1;
                        end else begin
                            ev[`USFD_IRQ_FERR] = 1'b1;
                        end
                    end
                end
            end
            default: begin
                st_next.rx_state = USFD_RX_IDLE;
            end
        endcase

        // armed detector restarts the frame on any falling edge while the receiver is busy
        if (st_reg.sfd_armed && fall && rx_busy) begin
            st_next.rx_state = USFD_RX_START;
            st_next.rx_ticks = 4'h0;
            st_next.sfd_armed = 1'b0;
        end

        // complete flag: new frame wins over a read in the same cycle
        if (ev[`USFD_IRQ_RXC]) begin
            st_next.rx_complete_flag = 1'b1;
        end
        // start flag lives only in standby; in active it reads zero
        if (ev[`USFD_IRQ_RXS]) begin
            st_next.rx_start_flag = 1'b1;
        end else if (!standby) begin
            st_next.rx_start_flag = 1'b0;
        end else if (bus.wr && hit(bus.addr, `USFD_OFF_STATUS)
                && bus.wdata[`USFD_ST_RXS]) begin
            st_next.rx_start_flag = 1'b0;
        end

        // transmitter, one bit every 16 ticks
        if (st_reg.tx_busy && tick) begin
            st_next.tx_ticks = 4'(st_reg.tx_ticks + 4'h1);
            if (st_reg.tx_ticks == `USFD_OVS_LAST) begin
                st_next.tx_shift = {1'b1, st_reg.tx_shift[9:1]};
                st_next.tx_bitn = 4'(st_reg.tx_bitn + 4'h1);
                if (st_reg.tx_bitn == 4'(`USFD_FRAME_BITS - 4'h1)) begin
                    st_next.tx_busy = 1'b0;
                    ev[`USFD_IRQ_TXDONE] = 1'b1;
                end
            end
        end
        st_next.tx_bit = st_next.tx_busy ? st_next.tx_shift[0] : 1'b1;

        // read data, one cycle after the strobe; unmapped reads give zero
        st_next.rdata = 32'h0000_0000;
        if (bus.rd) begin
            if (rd_rx) begin
                st_next.rdata = {24'h00_0000, st_reg.rx_data};
            end else if (hit(bus.addr, `USFD_OFF_STATUS)) begin
                st_next.rdata[`USFD_ST_RXC] = st_reg.rx_complete_flag;
                st_next.rdata[`USFD_ST_RXS] = st_reg.rx_start_flag & standby;
                st_next.rdata[`USFD_ST_TXBUSY] = st_reg.tx_busy;
                st_next.rdata[`USFD_ST_ARMED] = st_reg.sfd_armed;
            end else if (hit(bus.addr, `USFD_OFF_CTRL_SECOND)) begin
                st_next.rdata = {27'h000_0000, st_reg.ctrl};
            end else if (hit(bus.addr, `USFD_OFF_BAUD)) begin
                st_next.rdata = {16'h0000, st_reg.baud};
            end else if (hit(bus.addr, `USFD_OFF_INTSTAT)) begin
                st_next.rdata = {28'h000_0000, st_reg.int_stat};
            end else if (hit(bus.addr, `USFD_OFF_INTMASK)) begin
                st_next.rdata = {28'h000_0000, st_reg.int_mask};
            end
        end

        // sticky interrupt bits: read clears, an event in that cycle wins
        if (bus.rd && hit(bus.addr, `USFD_OFF_INTSTAT)) begin
            st_next.int_stat = ev;
        end else begin
            st_next.int_stat = st_reg.int_stat | ev;
        end
    end

    // single state register
    always_ff @(posedge mclk or posedge reset) begin
        if (reset) begin
            st_reg <= '0;
            st_reg.rx_state <= USFD_RX_IDLE;
            st_reg.rx_prev <= 1'b1;
            st_reg.tx_bit <= 1'b1;
            st_reg.tx_shift <= 10'h3FF;
            st_reg.ctrl <= usfd_ctrl_t'(`USFD_CTRL_SECOND_RST);
            st_reg.baud <= `USFD_BAUD_RST;
            st_reg.int_mask <= `USFD_MASK_RST;
        end else begin
            st_reg <= st_next;
        end
    end

    // checks on the documented behaviour
    property p_txd_drive_high;
        @(posedge mclk) disable iff (reset)
        (st_reg.ctrl.txd_dir_out && st_reg.tx_bit) |-> (!txd_oe_n && txd_o);
    endproperty
    a_txd_drive_high: assert property (p_txd_drive_high)
        else $error("txd not driven high with direction out");

    property p_arm_only_flag_low;
        @(posedge mclk) disable iff (reset)
        $rose(st_reg.sfd_armed) |-> (!st_reg.rx_complete_flag && !standby);
    endproperty
    a_arm_only_flag_low: assert property (p_arm_only_flag_low)
        else $error("detector armed with complete flag set or in standby");

    property p_read_arms;
        @(posedge mclk) disable iff (reset)
        (bus.rd && bus.addr == `USFD_OFF_RX_DATA && !bus.wr && !standby
            && st_reg.ctrl.sfd_en && st_reg.rx_state == USFD_RX_DATA
            && !(st_reg.sfd_armed && fall))
        |=> (st_reg.sfd_armed && !st_reg.rx_complete_flag);
    endproperty
    a_read_arms: assert property (p_read_arms)
        else $error("mid-frame data read did not arm detector");

    property p_false_start;
        @(posedge mclk) disable iff (reset)
        (st_reg.sfd_armed && fall && st_reg.rx_state != USFD_RX_IDLE)
        |=> (st_reg.rx_state == USFD_RX_START && st_reg.rx_ticks == 4'h0
            && !st_reg.sfd_armed);
    endproperty
    a_false_start: assert property (p_false_start)
        else $error("armed detector did not restart on falling edge");

    property p_restart_no_data;
        @(posedge mclk) disable iff (reset)
        (st_reg.sfd_armed && fall && st_reg.rx_state == USFD_RX_STOP)
        |=> !$rose(st_reg.rx_complete_flag) ##1 st_reg.rx_state != USFD_RX_IDLE;
    endproperty
    a_restart_no_data: assert property (p_restart_no_data)
        else $error("frame in progress completed despite restart");

    property p_start_flag_active;
        @(posedge mclk) disable iff (reset)
        !standby |=> (!standby |-> !st_reg.rx_start_flag);
    endproperty
    a_start_flag_active: assert property (p_start_flag_active)
        else $error("start flag set in active mode");

    property p_sfd_off;
        @(posedge mclk) disable iff (reset)
        (bus.wr && bus.addr == `USFD_OFF_CTRL_SECOND
            && !bus.wdata[`USFD_CB_DETECT_EN])
        |=> (!st_reg.sfd_armed && !st_reg.ctrl.sfd_en);
    endproperty
    a_sfd_off: assert property (p_sfd_off)
        else $error("detect enable write 0 left detector armed");

    property p_reenable_mid_frame;
        @(posedge mclk) disable iff (reset)
        (bus.wr && bus.addr == `USFD_OFF_CTRL_SECOND
            && bus.wdata[`USFD_CB_DETECT_EN]
            && !st_reg.ctrl.sfd_en && st_reg.rx_state != USFD_RX_IDLE
            && !(st_reg.sfd_armed && fall))
        |=> st_reg.sfd_armed;
    endproperty
    a_reenable_mid_frame: assert property (p_reenable_mid_frame)
        else $error("mid-frame re-enable did not arm detector");

    property p_complete_sets;
        @(posedge mclk) disable iff (reset)
        (st_reg.rx_state == USFD_RX_STOP && tick && rxd
            && st_reg.rx_ticks == `USFD_OVS_LAST
            && !(st_reg.sfd_armed && fall))
        |=> (st_reg.rx_complete_flag && st_reg.rx_data == $past(st_reg.rx_shift));
    endproperty
    a_complete_sets: assert property (p_complete_sets)
        else $error("complete flag not set after good stop bit");
endmodule // usfd_top

// [bench/usfd_remote.sv]
// remote serial partner: drives the receive line, decodes the txd wire
`timescale 1ns/1ps
module usfd_remote #(
    parameter int BIT_CLKS = 32
) (
    input wire logic mclk,
    input wire logic txd_o,
    input wire logic txd_oe_n,
    output logic rxd,
    output logic [7:0] got_byte,
    output logic got_valid
);
    logic line;

    // pull-up holds the wire high whenever the block lets go of it
    assign line = txd_oe_n ? 1'b1 : txd_o;

    // receive line idles high before any frame
    initial begin
        rxd = 1'b1;
        got_byte = 8'h00;
        got_valid = 1'b0;
    end

    // 8N1 lsb first; rx_case keeps this running while detection re-arms
    task automatic send_frame(input logic [7:0] b);
        logic [9:0] f;
        f = {1'b1, b, 1'b0};
        for (int i = 0; i < 10; i++) begin
            rxd <= f[i];
            repeat (BIT_CLKS) @(posedge mclk);
        end
    endtask

    // mid-bit sampling after each falling start edge, one byte only
    always begin
        @(negedge line);
        repeat (BIT_CLKS / 2) @(posedge mclk);
        for (int i = 0; i < 8; i++) begin
            repeat (BIT_CLKS) @(posedge mclk);
            got_byte[i] = line;
        end
        got_valid = 1'b1;
    end
endmodule // usfd_remote

// [bench/usfd_top_tb.sv]
// self-checking bench for the start-of-frame detector block
`timescale 1ns/1ps
`include "usfd_map.svh"
module usfd_top_tb;
    import usfd_pkg::*;
    // baud divisor 1 gives a tick every 2 clocks, 16 ticks a bit
    localparam int BIT_CLKS = 32;
    logic mclk;
    logic reset;
    usfd_bus_req_t bus;
    logic [31:0] rdata;
    logic standby;
    logic rxd;
    logic txd_o;
    logic txd_oe_n;
    logic irq;
    logic [7:0] got_byte;
    logic got_valid;
    logic [31:0] d;
    int failures;
    int checks_done;

    usfd_top usfd_top_inst (
        .mclk(mclk),
        .reset(reset),
        .bus(bus),
        .rdata(rdata),
        .standby(standby),
        .rxd_in(rxd),
        .txd_o(txd_o),
        .txd_oe_n(txd_oe_n),
        .irq(irq)
    );

    usfd_remote #(.BIT_CLKS(BIT_CLKS)) usfd_remote_inst (
        .mclk(mclk),
        .txd_o(txd_o),
        .txd_oe_n(txd_oe_n),
        .rxd(rxd),
        .got_byte(got_byte),
        .got_valid(got_valid)
    );

    // free-running 100 MHz clock
    initial begin
        mclk = 1'b0;
        forever #5 mclk = ~mclk;
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checks_done++;
        if (got !== exp) begin
            failures++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic test_done();
        if (failures == 0 && checks_done > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask

    // one idle cycle after each access keeps strobes from being set twice
    task automatic wr_reg(input logic [7:0] a, input logic [31:0] v);
        bus <= {a, v, 1'b1, 1'b0};
        @(posedge mclk);
        bus <= '0;
        @(posedge mclk);
    endtask

    task automatic rd_reg(input logic [7:0] a, output logic [31:0] v);
        bus <= {a, 32'h0000_0000, 1'b0, 1'b1};
        @(posedge mclk);
        bus <= '0;
        #1 v = rdata;
        @(posedge mclk);
    endtask

    // pins sampled mid-cycle: bit2 irq, bit1 txd_oe_n, bit0 txd_o
    task automatic chk_pins(input logic [31:0] exp);
        @(negedge mclk);
        chk({29'h0, irq, txd_oe_n, txd_o}, exp);
        @(posedge mclk);
    endtask

    task automatic wait_rxc();
        d = '0;
        for (int n = 0; n < 400 && d[0] !== 1'b1; n++)
            rd_reg(`USFD_OFF_STATUS, d);
        chk(d & 32'h0000_0001, 32'h0000_0001);
    endtask

    // frame 0x55 with a data read and a control write in bit 0
    task automatic rx_case(input logic [31:0] c0, input logic [31:0] c1,
            input logic [31:0] arm, input logic [31:0] exp);
        wr_reg(`USFD_OFF_CTRL_SECOND, c0);
        fork
            usfd_remote_inst.send_frame(8'h55);
            begin
                repeat (40) @(posedge mclk);
                rd_reg(`USFD_OFF_RX_DATA, d);
                wr_reg(`USFD_OFF_CTRL_SECOND, c1);
                rd_reg(`USFD_OFF_STATUS, d);
                chk(d & 32'h0000_0008, arm);
            end
        join
        wait_rxc();
        rd_reg(`USFD_OFF_RX_DATA, d);
        chk(d, exp);
        rd_reg(`USFD_OFF_STATUS, d);
        chk(d & 32'h0000_0003, 32'h0000_0000);
        rd_reg(`USFD_OFF_INTSTAT, d);
        chk(d, 32'h0000_0001);
    endtask

    // cuts a hang short well beyond the expected run length
    initial begin
        repeat (20000) @(posedge mclk);
        failures++;
        test_done();
    end

    // main sequence
    initial begin
        reset = 1'b1;
        bus = '0;
        standby = 1'b0;
        failures = 0;
        checks_done = 0;
        repeat (20) @(posedge mclk);
        reset <= 1'b0;
        @(posedge mclk);
        chk_pins(32'h0000_0003);
        rd_reg(`USFD_OFF_CTRL_SECOND, d);
        chk(d, 32'h0000_0000);
        rd_reg(`USFD_OFF_BAUD, d);
        chk(d, 32'h0000_0036);
        rd_reg(`USFD_OFF_INTMASK, d);
        chk(d, 32'h0000_0000);
        rd_reg(8'h40, d);
        chk(d, 32'h0000_0000);
        wr_reg(`USFD_OFF_BAUD, 32'h0000_0001);
        // 0x55 restarted at the bit1 falling edge reads back as 0xD5:
        // data bits 2..7, then the stop bit and idle line fill the top
        rx_case(32'h0000_0002, 32'h0000_0002, 32'h0, 32'h0000_0055);
        rx_case(32'h0000_0003, 32'h0000_0003, 32'h8, 32'h0000_00D5);
        rx_case(32'h0000_0003, 32'h0000_0002, 32'h0, 32'h0000_0055);
        rx_case(32'h0000_0002, 32'h0000_0003, 32'h8, 32'h0000_00D5);
        // standby: a start edge now sets the start flag and interrupts
        wr_reg(`USFD_OFF_INTMASK, 32'h0000_0002);
        wr_reg(`USFD_OFF_CTRL_SECOND, 32'h0000_0003);
        standby <= 1'b1;
        usfd_remote_inst.send_frame(8'h55);
        wait_rxc();
        chk(d & 32'h0000_0002, 32'h0000_0002);
        chk_pins(32'h0000_0007);
        wr_reg(`USFD_OFF_INTMASK, 32'h0000_0000);
        chk_pins(32'h0000_0003);
        wr_reg(`USFD_OFF_INTMASK, 32'h0000_0002);
        chk_pins(32'h0000_0007);
        rd_reg(`USFD_OFF_INTSTAT, d);
        chk(d, 32'h0000_0003);
        chk_pins(32'h0000_0003);
        wr_reg(`USFD_OFF_STATUS, 32'h0000_0002);
        standby <= 1'b0;
        rd_reg(`USFD_OFF_STATUS, d);
        chk(d & 32'h0000_0002, 32'h0000_0000);
        rd_reg(`USFD_OFF_RX_DATA, d);
        chk(d, 32'h0000_0055);
        // txd as output drives high even with open-drain selected
        wr_reg(`USFD_OFF_CTRL_SECOND, 32'h0000_001C);
        chk_pins(32'h0000_0001);
        wr_reg(`USFD_OFF_CTRL_SECOND, 32'h0000_000C);
        chk_pins(32'h0000_0002);
        wr_reg(`USFD_OFF_TXDATA, 32'h0000_00A5);
        // transmitter reports busy while the frame goes out
        rd_reg(`USFD_OFF_STATUS, d);
        chk(d & 32'h0000_0004, 32'h0000_0004);
        for (int n = 0; n < 600 && got_valid !== 1'b1; n++)
            @(posedge mclk);
        chk({24'h0, got_byte}, 32'h0000_00A5);
        repeat (2 * BIT_CLKS) @(posedge mclk);
        rd_reg(`USFD_OFF_INTSTAT, d);
        chk(d, 32'h0000_0004);
        test_done();
    end
endmodule // usfd_top_tb
